// File: pkg/osc_pkg.sv
package osc_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int   NUM_OUT     = 8;

  // ------------------------------------------------------------
  // Command bit meaning (low means conducting)
  // ------------------------------------------------------------
  localparam logic CMD_ON      = 1'h0;
  localparam logic CMD_OFF     = 1'h1;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic RX_RST_BIT  = CMD_OFF;
  localparam logic CMD_RST_BIT = CMD_OFF;
  localparam logic FAULT_RST   = 1'h0;
  localparam logic GATE_RST    = 1'h0;
  localparam logic ILIM_RST    = 1'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int   MCLK_PS     = 5000;
  localparam int   RST_MIN_PS  = 250000;
  localparam int   RST_MIN_CYC = (RST_MIN_PS + MCLK_PS - 1) / MCLK_PS;

endpackage

// File: core/osc_sync.sv
`timescale 1ns/100ps

module osc_sync #(
  parameter int W = 1
)(
  // Clock
  input  wire logic         clk,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // ------------------------------------------------------------
  // Two-stage synchroniser, free running
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    meta <= d;
    q    <= meta;
  end

endmodule

// File: core/osc_core.sv
`timescale 1ns/100ps

// Summary of operation
// - SI shifts into the input register on each falling SCLK edge while selected.
// - SO moves to the next bit after each rising SCLK edge.
// - Deselected: SCLK and SI ignored, SO driver off.
// - Command bit one turns its switch off, zero turns it on.
// - Eight-bit word, first bit controls output 7, last output 0.
// - Input register holds eight bits, full after eight clocks in a frame.
// - Chip select rising copies the input register to the switch latch.
// - Chip select falling enables SO and loads drain status.
// - Status bit high for off output, low for on output.
// - Status reflects previous command, output 7 first.
// - Reset leaves the SO pin behaviour untouched.
// - Reset sets every input register bit to one (off) and turns every switch off.
// - Protection disabled: shorted output stays on, current limited.
// - Protection enabled: a short latches off only that output.

module osc_core
  import osc_pkg::*;
#(
  parameter int N = NUM_OUT
)(
  // System
  input  wire logic         mclk,
  input  wire logic         rst_b,
  // Serial link
  input  wire logic         sclk,
  input  wire logic         cs_b,
  input  wire logic         si,
  output logic              so,
  output logic              so_oe,
  // Protection strap and sense
  input  wire logic         short_protect_disable,
  input  wire logic [N-1:0] drain_high,
  input  wire logic [N-1:0] short_det,
  input  wire logic [N-1:0] therm_sd,
  // Power switch drive
  output logic      [N-1:0] gate_on,
  output logic      [N-1:0] ilim_on
);

  localparam int SW = 3 * N + 3;

  logic [SW-1:0] sync_d;
  logic [SW-1:0] sync_q;
  logic          cs_s;
  logic          sclk_s;
  logic          spd_s;
  logic [N-1:0]  drain_s;
  logic [N-1:0]  short_s;
  logic [N-1:0]  therm_s;
  logic          cs_q;
  logic          sclk_q;
  wire           cs_fall;
  wire           cs_rise;
  wire           sclk_rise;
  logic [N-1:0]  rx_sh;
  logic [N-1:0]  tx_sh;
  logic [N-1:0]  next_tx;
  logic [N-1:0]  latch_cmd;
  logic [N-1:0]  next_cmd;
  logic [N-1:0]  fault;
  logic [N-1:0]  fault_set;
  logic [N-1:0]  next_fault;
  logic [N-1:0]  next_gate;
  logic [N-1:0]  next_ilim;
  logic [N-1:0]  kill;
  logic          rx_armed;
  logic          tx_valid;

  // ------------------------------------------------------------
  // Link-side receive register, clocked by the serial clock
  // ------------------------------------------------------------
  always_ff @(negedge sclk or negedge rst_b)
  begin
    if (!rst_b)
      rx_sh <= {N{RX_RST_BIT}};
    else if (!cs_b)
      rx_sh <= {rx_sh[N-2:0], si};
  end

  // ------------------------------------------------------------
  // Shift seen since reset, for the receive checks
  // ------------------------------------------------------------
  always_ff @(negedge sclk or negedge rst_b)
  begin
    if (!rst_b)
      rx_armed <= 1'h0;
    else if (!cs_b)
      rx_armed <= 1'h1;
  end

  // ------------------------------------------------------------
  // Pin synchronisers into the system clock
  // ------------------------------------------------------------
  assign sync_d = {therm_sd, short_det, drain_high, short_protect_disable, sclk, cs_b};

  osc_sync #(
    .W (SW)
  ) u_sync (
    .clk (mclk),
    .d   (sync_d),
    .q   (sync_q)
  );

  assign cs_s    = sync_q[0];
  assign sclk_s  = sync_q[1];
  assign spd_s   = sync_q[2];
  assign drain_s = sync_q[N+2:3];
  assign short_s = sync_q[2*N+2:N+3];
  assign therm_s = sync_q[3*N+2:2*N+3];

  // ------------------------------------------------------------
  // Frame edge detection
  // ------------------------------------------------------------
  assign cs_fall   = cs_q & ~cs_s;
  assign cs_rise   = ~cs_q & cs_s;
  assign sclk_rise = ~sclk_q & sclk_s & ~cs_s;

  // ------------------------------------------------------------
  // Serial output path, deliberately outside reset
  // ------------------------------------------------------------
  assign next_tx = cs_fall   ? drain_s :
                   sclk_rise ? {tx_sh[N-2:0], 1'h0} :
                   tx_sh;

  always_ff @(posedge mclk)
  begin
    cs_q   <= cs_s;
    sclk_q <= sclk_s;
    tx_sh  <= next_tx;
    so_oe  <= ~cs_s;
  end

  assign so = tx_sh[N-1];

  // ------------------------------------------------------------
  // Command latch and per-output protection
  // ------------------------------------------------------------
  assign next_cmd = cs_rise ? rx_sh : latch_cmd;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_out
      assign fault_set[gi]  = gate_on[gi] & ((short_s[gi] & ~spd_s) | therm_s[gi]);
      assign next_fault[gi] = fault_set[gi] | (fault[gi] & ~cs_rise);
      assign next_gate[gi]  = (next_cmd[gi] == CMD_ON) & ~next_fault[gi];
      assign next_ilim[gi]  = next_gate[gi] & short_s[gi] & spd_s;
      assign kill[gi]       = gate_on[gi] & short_s[gi] & ~spd_s;
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      latch_cmd <= {N{CMD_RST_BIT}};
      fault     <= {N{FAULT_RST}};
      gate_on   <= {N{GATE_RST}};
      ilim_on   <= {N{ILIM_RST}};
    end
    else
    begin
      latch_cmd <= next_cmd;
      fault     <= next_fault;
      gate_on   <= next_gate;
      ilim_on   <= next_ilim;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      tx_valid <= 1'h0;
    else if (cs_fall)
      tx_valid <= 1'h1;
  end

  a_rx_shift_order: assert property (
    @(negedge sclk) disable iff (!rst_b)
    (!cs_b && $past(!cs_b) && rx_armed) |-> (rx_sh[N-1:1] == $past(rx_sh[N-2:0]))
  ) else $error("input register did not shift by one bit");

  a_cmd_latch_copy: assert property (
    @(posedge mclk) disable iff (!rst_b)
    cs_rise |=> (latch_cmd == $past(rx_sh))
  ) else $error("command latch missed the input register");

  a_status_load: assert property (
    @(posedge mclk) disable iff (!rst_b)
    cs_fall |=> (tx_sh == $past(drain_s)) && so_oe && (so == $past(drain_s[N-1]))
  ) else $error("status word not loaded at frame start");

  a_so_shift_msb: assert property (
    @(posedge mclk)
    (sclk_rise && !cs_fall) |=> (tx_sh == ($past(tx_sh) << 1))
  ) else $error("serial output did not advance on clock rise");

  a_so_idle_off: assert property (
    @(posedge mclk)
    cs_s ##1 cs_s |=> !so_oe
  ) else $error("serial output driven while deselected");

  a_reset_all_off: assert property (
    @(posedge mclk)
    !rst_b |-> (gate_on == '0) && (latch_cmd == {N{CMD_OFF}})
  ) else $error("switches not off under reset");

  a_inverted_cmd: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ##1 ((gate_on & latch_cmd) == '0)
  ) else $error("switch on while its command bit is one");

  a_short_latch_one: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ((kill != '0) && !cs_rise && (therm_s == '0))
      |=> ((gate_on & $past(kill)) == '0)
          && ((gate_on & ~$past(kill)) == ($past(gate_on) & ~$past(kill)))
          && ((fault & $past(kill)) == $past(kill))
  ) else $error("short did not latch off only its own output");

  a_limit_hold_on: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (spd_s && !cs_rise && (therm_s == '0)) |=> (gate_on == $past(gate_on))
  ) else $error("output dropped while short protection disabled");

  a_rx_idle_hold: assert property (
    @(negedge sclk) disable iff (!rst_b)
    cs_b
      |=> (rx_sh == $past(rx_sh))
  ) else $error("input register moved while deselected");

  a_latch_only_rise: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !cs_rise
      |=> (latch_cmd == $past(latch_cmd))
  ) else $error("command latch changed outside chip select rise");

  a_gate_follow_cmd: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (cs_rise && (short_s == '0) && (therm_s == '0))
      |=> (gate_on == ~$past(rx_sh))
  ) else $error("switches do not follow the new command word");

  a_tx_idle_hold: assert property (
    @(posedge mclk)
    (cs_s && tx_valid)
      |=> $stable(tx_sh)
  ) else $error("status register moved while deselected");

  a_so_stands: assert property (
    @(posedge mclk)
    (tx_valid && !sclk_rise && !cs_fall)
      |=> $stable(tx_sh)
  ) else $error("serial output moved without a clock rise");

  a_so_zero_fill: assert property (
    @(posedge mclk)
    (sclk_rise && !cs_fall)
      |=> (tx_sh[0] == 1'h0)
  ) else $error("status register did not fill with zeros");

  a_oe_on_select: assert property (
    @(posedge mclk)
    !cs_s
      |=> so_oe
  ) else $error("serial output not driven while selected");

  a_ilim_needs_strap: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !spd_s
      |=> (ilim_on == '0)
  ) else $error("current limit mode with short protection enabled");

  a_ilim_on_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ((ilim_on & ~gate_on) == '0)
  ) else $error("current limit flagged on an output that is off");

  a_reset_rx_clear: assert property (
    @(posedge mclk)
    !rst_b
      |-> (rx_sh == {N{RX_RST_BIT}}) && (ilim_on == '0) && (fault == '0)
  ) else $error("input register or fault state not cleared by reset");

  a_fault_hold_frame: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ((fault != '0) && !cs_rise)
      |=> ((fault & $past(fault)) == $past(fault))
  ) else $error("latched fault released before a new command");

  a_therm_turn_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ((therm_s & gate_on) != '0)
      |=> ((gate_on & $past(therm_s & gate_on)) == '0)
  ) else $error("output stayed on through thermal shutdown");

endmodule

// File: test/osc_master.sv
`timescale 1ns/100ps

module osc_master (
  // Serial link
  input  wire logic       so,
  output logic            sclk,
  output logic            cs_b,
  output logic            si,
  // Captured status
  output logic            done,
  output logic [7:0]      got
);
  initial
  begin
    sclk = 1'h0;
    cs_b = 1'h1;
    si   = 1'h0;
    done = 1'h0;
    got  = 8'h00;
  end

  // ----------------------------------------
  // One frame, 160 ns link period
  // ----------------------------------------
  task automatic xfer(input logic [7:0] cmd, input int nbits);
    begin
      cs_b = 1'h0;
      #80;
      for (int i = 7; i > 7 - nbits; i--)
      begin
        si = cmd[i];
        #40;
        got[i] = so;
        sclk   = 1'h1;
        #80;
        sclk   = 1'h0;
        #40;
      end
      si = ~si;
      #40;
      cs_b = 1'h1;
      done = (nbits == 8);
      #160;
      done = 1'h0;
    end
  endtask

  // ----------------------------------------
  // Clock pulses while deselected
  // ----------------------------------------
  task automatic idle_clk(input int n);
    begin
      for (int i = 0; i < n; i++)
      begin
        #40;
        si   = ~si;
        sclk = 1'h1;
        #80;
        sclk = 1'h0;
        #40;
      end
    end
  endtask
endmodule

// File: test/octal_switch_serial_control_test.sv
`timescale 1ns/100ps

module octal_switch_serial_control_test;
  import osc_pkg::*;
  logic            mclk, rst_b, spd;
  logic      [7:0] short_det, therm_sd, exp_gate, cmd;
  wire logic       sclk, cs_b, si, so, so_oe, so_pin, done;
  wire logic [7:0] gate_on, ilim_on, got, drain_high;
  int              err_total, samples_checked;
  logic      [7:0] exp_q[$];

  assign drain_high = ~gate_on;
  assign so_pin     = so_oe ? so : 1'hZ;

  osc_core dut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .si(si), .so(so),
    .so_oe(so_oe), .short_protect_disable(spd), .drain_high(drain_high),
    .short_det(short_det), .therm_sd(therm_sd), .gate_on(gate_on), .ilim_on(ilim_on));
  osc_master m (.so(so_pin), .sclk(sclk), .cs_b(cs_b), .si(si), .done(done), .got(got));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge done)
    check(got, exp_q.pop_front());

  task automatic settle();
    repeat (10) @(negedge mclk);
  endtask

  task automatic frame(input logic [7:0] c, input logic [7:0] eg);
    exp_q.push_back(~exp_gate);
    @(negedge mclk);
    #1.3;
    m.xfer(c, 8);
    settle();
    exp_gate = eg;
    check(gate_on, eg);
    check({7'h00, so_oe}, 8'h00);
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    #100000;
    err_total++;
    print_verdict();
  end

  initial
  begin
    rst_b = 1'h1;
    spd = 1'h0;
    short_det = 8'h00;
    therm_sd = 8'h00;
    exp_gate = 8'h00;
    err_total = 0;
    samples_checked = 0;
    void'($urandom(32'h67E1EDE5));
    #1;
    rst_b = 1'h0;
    repeat (RST_MIN_CYC) @(negedge mclk);
    check(gate_on, 8'h00);
    rst_b = 1'h1;
    frame(8'h5A, 8'hA5);
    m.idle_clk(4);
    m.xfer(8'h00, 0);
    settle();
    check(gate_on, 8'hA5);
    for (int k = 0; k < 6; k++)
    begin
      cmd = 8'($urandom);
      frame(cmd, ~cmd);
    end
    $display("command test done");
    frame(8'h00, 8'hFF);
    short_det = 8'h08;
    settle();
    exp_gate = 8'hF7;
    check(gate_on, 8'hF7);
    short_det = 8'h00;
    frame(8'h00, 8'hFF);
    spd = 1'h1;
    short_det = 8'h08;
    settle();
    check(gate_on, 8'hFF);
    check(ilim_on, 8'h08);
    therm_sd = 8'h20;
    settle();
    exp_gate = 8'hDF;
    check(gate_on, 8'hDF);
    short_det = 8'h00;
    therm_sd = 8'h00;
    spd = 1'h0;
    frame(8'h00, 8'hFF);
    $display("fault test done");
    rst_b = 1'h0;
    repeat (RST_MIN_CYC) @(negedge mclk);
    check(gate_on, 8'h00);
    check(ilim_on, 8'h00);
    rst_b = 1'h1;
    exp_gate = 8'h00;
    m.xfer(8'h00, 0);
    settle();
    check(gate_on, 8'h00);
    frame(8'h3C, 8'hC3);
    m.xfer(8'hA0, 4);
    settle();
    check(gate_on, 8'h35);
    $display("reset test done");
    print_verdict();
  end
endmodule
